// >>> snt_consts.svh
// constants of the s-bus nt layer-1 transceiver
`ifndef SNT_CONSTS_SVH
`define SNT_CONSTS_SVH
// clock and line rate
`define SNT_CLK_KHZ                    100000
`define SNT_LINE_KBPS                  192
`define SNT_BIT_CYC                    ((`SNT_CLK_KHZ + `SNT_LINE_KBPS - 1) / `SNT_LINE_KBPS)
// supervision times in ms
`define SNT_T8_MS                      8
`define SNT_T16_MS                     16
`define SNT_T32_MS                     32
// frame layout
`define SNT_LAST_POS                   6'h2F
`define SNT_RX_OFFSET                  6'h02
`define SNT_RX_WRAP                    6'h2E
`define SNT_POS_F                      6'h00
`define SNT_POS_L1                     6'h01
`define SNT_POS_A                      6'h0C
`define SNT_POS_FA                     6'h0D
`define SNT_POS_N                      6'h0E
`define SNT_POS_M                      6'h19
`define SNT_POS_E0                     6'h0A
`define SNT_POS_E1                     6'h17
`define SNT_POS_E2                     6'h22
`define SNT_POS_E3                     6'h2D
`define SNT_WORD_BITS                  36
`define SNT_CMD_REPEAT                 2
`define SNT_SYNC_FULL                  2'h3
// commands from upstream
`define SNT_DEACT_REQUEST_CMD          4'h0
`define SNT_RESET_CMD                  4'h1
`define SNT_SINGLE_PULSE_TEST          4'h2
`define SNT_CONTINUOUS_PULSE_TEST      4'h3
`define SNT_NOT_IN_SYNC_CODE           4'h4
`define SNT_START_ACTIVATION_CODE      4'h8
`define SNT_START_ACTIVATION_LOOP_CODE 4'hA
`define SNT_ACTIVATION_DONE_CODE       4'hC
`define SNT_LOOP_SWITCH_THROUGH_CODE   4'hE
`define SNT_DEACT_CONFIRM_CMD          4'hF
// indications toward upstream
`define SNT_INTERIM_CLOCKING_IND       4'h0
`define SNT_DEACT_DONE_IND             4'hF
// test select pin codes
`define SNT_TEST_CONT                  3'h2
`define SNT_TEST_SINGLE                3'h3
`endif

// >>> snt_pkg.sv
// types of the s-bus nt layer-1 transceiver
package snt_pkg;
  // activation states, gray coded along the activation path
  typedef enum logic [3:0] {
    reset_state              = 4'h0,
    idle_state               = 4'h1,
    level_state              = 4'h3,
    pending_activation_state = 4'h2,
    wait_switch_state        = 4'h6,
    activated_state          = 4'h7,
    pending_deact_state      = 4'h5,
    wait_confirm_state       = 4'h4,
    lost_line_state          = 4'hC,
    lost_up_state            = 4'hD
  } snt_state_t;
  // signal sent toward the terminals
  typedef enum logic [1:0] {
    info_zero = 2'h0,
    info_two  = 2'h1,
    info_four = 2'h2
  } snt_info_t;
endpackage

// >>> snt_cmd_filter.sv
// accepts an upstream command code only after repeated equal frames
`timescale 1ns/10ps
`include "snt_consts.svh"
module snt_cmd_filter #(
  parameter int         REPEAT   = `SNT_CMD_REPEAT,
  parameter logic [3:0] RST_CODE = `SNT_DEACT_CONFIRM_CMD
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       frame_i,
  input  wire logic [3:0] code_i,
  output logic      [3:0] code_o
);
  logic [3:0] last;       // code seen in the previous frame
  logic [3:0] run;        // frames the same code has been seen
  logic [3:0] next_last;
  logic [3:0] next_run;
  logic [3:0] next_code;

  // count equal frames, take the code once the count is reached
  always_comb begin
    next_last = last;
    next_run  = run;
    next_code = code_o;
    if (frame_i) begin
      if (code_i == last) begin
        if (run != 4'hF) begin
          next_run = run + 4'h1;
        end
      end else begin
        next_last = code_i;
        next_run  = 4'h1;
      end
      if (next_run >= 4'(REPEAT)) begin
        next_code = next_last;
      end
    end
  end

  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last   <= RST_CODE;
      run    <= 4'h0;
      code_o <= RST_CODE;
    end else begin
      last   <= next_last;
      run    <= next_run;
      code_o <= next_code;
    end
  end
endmodule

// >>> snt_buf2.sv
// small fifo with valid and ready on both sides
`timescale 1ns/10ps
module snt_buf2 #(
  parameter int W     = 36,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] in_word_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic      [W-1:0] out_word_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH]; // storage flops
  logic [AW-1:0] wr;         // write index
  logic [AW-1:0] rd;         // read index
  logic [AW:0]   cnt;        // entries held
  logic [AW-1:0] next_wr;
  logic [AW-1:0] next_rd;
  logic [AW:0]   next_cnt;
  logic          push;
  logic          pop;

  assign out_word_o = mem[rd];

  // pointer and fill arithmetic, flags registered for clean outputs
  always_comb begin
    push     = in_valid_i & in_ready_o;
    pop      = out_ready_i & out_valid_o;
    next_wr  = wr;
    next_rd  = rd;
    if (push) begin
      next_wr = (wr == AW'(DEPTH - 1)) ? '0 : wr + AW'(1);
    end
    if (pop) begin
      next_rd = (rd == AW'(DEPTH - 1)) ? '0 : rd + AW'(1);
    end
    next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr          <= '0;
      rd          <= '0;
      cnt         <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      wr          <= next_wr;
      rd          <= next_rd;
      cnt         <= next_cnt;
      in_ready_o  <= (next_cnt != (AW+1)'(DEPTH));
      out_valid_o <= (next_cnt != '0);
    end
  end

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr] <= in_word_i;
    end
  end
endmodule

// >>> snt_top.sv
// s-bus nt layer-1 transceiver: line coding, framing and activation
// Notes on behaviour
// - one is silence, zeros alternate pulse polarity
// - frame bit is positive violating zero pulse
// - 48-bit frames at 192 kbit/s
// - balance bit zero when zero count odd
// - echo bit repeats last received signalling bit
// - activation bit: info 2 zero, info 4 one
// - data passes only when activated, else ones
// - loopback forces echo zero, equal channel delay
// - single pulse per frame or continuous pulses
// - test pins send pulses, no state change
// - hardware reset: reset state, interim indication
// - idle: interim indication for 8 ms, then done
// - line signal while idle: report activation request
// - start command: send info 2, loop variant
// - info 3 received: keep info 2, await switch
// - switch-through: info 4, transparent, loop variant
// - lost sync or upstream loss: send info 2
// - deact done: 16 ms quiet or 32 ms
// - wait for deact confirm, then idle again
// - deact request starts complete deactivation, info 0
// - reset command: unconditional, info 0, ignore line
// - info 2 carries zero data, echo, activation
`timescale 1ns/10ps
`include "snt_consts.svh"
module snt_top #(
  parameter logic [9:0]  BIT_CYC = 10'(`SNT_BIT_CYC),
  parameter logic [23:0] T8_CYC  = 24'(`SNT_T8_MS * `SNT_CLK_KHZ),
  parameter logic [23:0] T16_CYC = 24'(`SNT_T16_MS * `SNT_CLK_KHZ),
  parameter logic [23:0] T32_CYC = 24'(`SNT_T32_MS * `SNT_CLK_KHZ)
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      rx_pos_i,
  input  wire logic                      rx_neg_i,
  input  wire logic [2:0]                test_select_pins_i,
  output logic                           tx_pos_o,
  output logic                           tx_neg_o,
  input  wire logic                      sys_frame_i,
  input  wire logic [3:0]                sys_cmd_i,
  output logic      [3:0]                sys_ind_o,
  input  wire logic [`SNT_WORD_BITS-1:0] sys_tx_word_i,
  input  wire logic                      sys_tx_valid_i,
  output logic                           sys_tx_ready_o,
  output logic      [`SNT_WORD_BITS-1:0] sys_rx_word_o,
  output logic                           sys_rx_valid_o,
  output logic                           loop_closed_o
);
  localparam int WB = `SNT_WORD_BITS;

  // data bit lookup: bit 6 marks a data bit, [5:0] its word index
  function automatic logic [6:0] snt_map(input logic [5:0] p);
    logic [6:0] r;
    r = 7'h00;
    if (p >= 6'h02 && p <= 6'h09) r = {1'b1, 6'h25 - p};
    if (p >= 6'h0F && p <= 6'h16) r = {1'b1, 6'h2A - p};
    if (p >= 6'h1A && p <= 6'h21) r = {1'b1, 6'h2D - p};
    if (p >= 6'h25 && p <= 6'h2C) r = {1'b1, 6'h30 - p};
    if (p == 6'h0B) r = 7'h43;
    if (p == 6'h18) r = 7'h42;
    if (p == 6'h23) r = 7'h41;
    if (p == 6'h2E) r = 7'h40;
    return r;
  endfunction

  // ---------------- pin synchronisers ----------------
  logic [4:0] pin_s1;      // first stage, read only by pin_s2
  logic [4:0] pin_s2;
  logic [4:0] pin_s3;
  logic [4:0] pin_v;       // accepted pin levels
  logic [4:0] next_pin_v;

  // accept a pin level once the last two stages agree
  always_comb begin
    next_pin_v = pin_v;
    for (int i = 0; i < 5; i++) begin
      if (pin_s2[i] == pin_s3[i]) next_pin_v[i] = pin_s3[i];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      pin_s3 <= 5'h00;
      pin_v  <= 5'h00;
    end else begin
      pin_s1 <= {test_select_pins_i, rx_neg_i, rx_pos_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_v  <= next_pin_v;
    end
  end

  // ---------------- bit and frame timing ----------------
  logic [9:0] div_cnt;     // clocks within one bit
  logic       bit_tick;    // one-cycle bit enable
  logic [5:0] tx_pos;      // bit position in the sent frame
  logic [9:0] next_div;
  logic       next_tick;
  logic [5:0] next_tx_pos;
  logic [5:0] rx_pos;      // bit position in the received frame

  // divider gives the 192 kbit/s bit enable, 48 bits per frame
  always_comb begin
    next_div    = (div_cnt == BIT_CYC - 10'h001) ? 10'h000 : div_cnt + 10'h001;
    next_tick   = (div_cnt == BIT_CYC - 10'h001);
    next_tx_pos = tx_pos;
    if (bit_tick) begin
      next_tx_pos = (tx_pos == `SNT_LAST_POS) ? 6'h00 : tx_pos + 6'h01;
    end
    // terminal frames arrive two bits behind ours
    rx_pos = (tx_pos >= `SNT_RX_OFFSET) ? tx_pos - `SNT_RX_OFFSET : tx_pos + `SNT_RX_WRAP;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt  <= 10'h000;
      bit_tick <= 1'b0;
      tx_pos   <= 6'h00;
    end else begin
      div_cnt  <= next_div;
      bit_tick <= next_tick;
      tx_pos   <= next_tx_pos;
    end
  end

  // ---------------- command filter and send buffer ----------------
  logic [3:0]    cmd;      // accepted upstream command
  logic [WB-1:0] buf_word;
  logic          buf_valid;
  logic          frame_end;

  assign frame_end = bit_tick & (tx_pos == `SNT_LAST_POS);

  snt_cmd_filter #(
    .REPEAT   (`SNT_CMD_REPEAT),
    .RST_CODE (`SNT_DEACT_CONFIRM_CMD)
  ) u_filter (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .frame_i (sys_frame_i),
    .code_i  (sys_cmd_i),
    .code_o  (cmd)
  );

  // one word leaves per frame; an early source stalls on ready
  snt_buf2 #(
    .W     (WB),
    .DEPTH (2)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_word_i   (sys_tx_word_i),
    .in_valid_i  (sys_tx_valid_i),
    .in_ready_o  (sys_tx_ready_o),
    .out_word_o  (buf_word),
    .out_valid_o (buf_valid),
    .out_ready_i (frame_end)
  );

  // ---------------- activation state machine ----------------
  snt_pkg::snt_state_t state;
  snt_pkg::snt_state_t next_state;
  logic        loop;       // loopback closed
  logic [23:0] tmr;        // time in current state
  logic [23:0] quiet;      // time without a received pulse
  logic [1:0]  sync_cnt;   // received frame alignment score
  logic        next_loop;
  logic [23:0] next_tmr;
  logic [23:0] next_quiet;
  logic [3:0]  next_ind;
  logic        rx_pulse;   // pulse seen on this bit, line not ignored
  logic        line_ok;    // info 3 in frame, or our own loop
  logic        is_start;
  logic        is_switch;

  always_comb begin
    is_start  = (cmd == `SNT_START_ACTIVATION_CODE) | (cmd == `SNT_START_ACTIVATION_LOOP_CODE);
    is_switch = (cmd == `SNT_ACTIVATION_DONE_CODE) | (cmd == `SNT_LOOP_SWITCH_THROUGH_CODE);
    line_ok   = loop | (sync_cnt == `SNT_SYNC_FULL);
    next_state = state;
    next_loop  = loop;
    if (cmd == `SNT_RESET_CMD) begin
      next_state = snt_pkg::reset_state;
    end else if (cmd == `SNT_DEACT_REQUEST_CMD && state != snt_pkg::reset_state &&
                 state != snt_pkg::idle_state && state != snt_pkg::pending_deact_state &&
                 state != snt_pkg::wait_confirm_state) begin
      next_state = snt_pkg::pending_deact_state;
    end else begin
      unique case (state)
        snt_pkg::reset_state: begin
          if (cmd == `SNT_DEACT_CONFIRM_CMD) next_state = snt_pkg::idle_state;
        end
        snt_pkg::idle_state, snt_pkg::level_state: begin
          if (is_start) begin
            next_state = snt_pkg::pending_activation_state;
            next_loop  = (cmd == `SNT_START_ACTIVATION_LOOP_CODE);
          end else if (rx_pulse) begin
            next_state = snt_pkg::level_state;
          end
        end
        snt_pkg::pending_activation_state: begin
          if (line_ok) next_state = snt_pkg::wait_switch_state;
        end
        snt_pkg::wait_switch_state, snt_pkg::lost_up_state: begin
          if (is_switch) begin
            next_state = snt_pkg::activated_state;
            next_loop  = (cmd == `SNT_LOOP_SWITCH_THROUGH_CODE);
          end
        end
        snt_pkg::activated_state: begin
          if (cmd == `SNT_NOT_IN_SYNC_CODE) next_state = snt_pkg::lost_up_state;
          else if (!line_ok) next_state = snt_pkg::lost_line_state;
        end
        snt_pkg::lost_line_state: begin
          if (line_ok) next_state = snt_pkg::activated_state;
        end
        snt_pkg::pending_deact_state: begin
          if (quiet >= T16_CYC || tmr >= T32_CYC) begin
            next_state = snt_pkg::wait_confirm_state;
          end
        end
        snt_pkg::wait_confirm_state: begin
          if (cmd == `SNT_DEACT_CONFIRM_CMD) next_state = snt_pkg::idle_state;
        end
        default: next_state = snt_pkg::reset_state;
      endcase
    end
    if (next_state == snt_pkg::reset_state || next_state == snt_pkg::pending_deact_state) begin
      next_loop = 1'b0;
    end
    next_tmr   = (next_state != state) ? 24'h000000 :
                 ((tmr == 24'hFFFFFF) ? tmr : tmr + 24'h000001);
    next_quiet = rx_pulse ? 24'h000000 : ((quiet == 24'hFFFFFF) ? quiet : quiet + 24'h000001);
    // indication per state
    unique case (next_state)
      snt_pkg::reset_state:         next_ind = `SNT_INTERIM_CLOCKING_IND;
      snt_pkg::idle_state:          next_ind = (next_tmr < T8_CYC) ? `SNT_INTERIM_CLOCKING_IND :
                                               `SNT_DEACT_DONE_IND;
      snt_pkg::activated_state:     next_ind = `SNT_ACTIVATION_DONE_CODE;
      snt_pkg::lost_line_state,
      snt_pkg::lost_up_state:       next_ind = `SNT_NOT_IN_SYNC_CODE;
      snt_pkg::pending_deact_state: next_ind = `SNT_INTERIM_CLOCKING_IND;
      snt_pkg::wait_confirm_state:  next_ind = `SNT_DEACT_DONE_IND;
      default:                      next_ind = `SNT_START_ACTIVATION_CODE;
    endcase
  end

  // hardware reset lands in the reset state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state         <= snt_pkg::reset_state;
      loop          <= 1'b0;
      loop_closed_o <= 1'b0;
      tmr           <= 24'h000000;
      quiet         <= 24'h000000;
      sys_ind_o     <= `SNT_INTERIM_CLOCKING_IND;
    end else begin
      state         <= next_state;
      loop          <= next_loop;
      loop_closed_o <= next_loop;
      tmr           <= next_tmr;
      quiet         <= next_quiet;
      sys_ind_o     <= next_ind;
    end
  end

  // ---------------- receive path ----------------
  logic [WB-1:0] rx_word;   // bits collected this frame
  logic          echo;      // last received signalling bit
  logic [WB-1:0] tx_word;   // word being sent this frame
  logic [WB-1:0] next_rx_word;
  logic          next_echo;
  logic [1:0]    next_sync;
  logic [WB-1:0] next_out;
  logic          next_out_valid;
  logic [6:0]    rx_map;

  // line ignored in reset state and while looped
  always_comb begin
    rx_pulse       = bit_tick & (pin_v[0] | pin_v[1]) & ~loop &
                     (state != snt_pkg::reset_state);
    rx_map         = snt_map(rx_pos);
    next_rx_word   = rx_word;
    next_echo      = echo;
    next_sync      = sync_cnt;
    next_out       = sys_rx_word_o;
    next_out_valid = 1'b0;
    if (bit_tick) begin
      if (rx_map[6]) begin
        next_rx_word[rx_map[5:0]] = ~rx_pulse;
        if (rx_map[5:2] == 4'h0) next_echo = ~rx_pulse;
      end
      if (rx_pos == `SNT_POS_F) begin
        if (rx_pulse & pin_v[0] & ~pin_v[1]) begin
          if (sync_cnt != `SNT_SYNC_FULL) next_sync = sync_cnt + 2'h1;
        end else if (sync_cnt != 2'h0) begin
          next_sync = sync_cnt - 2'h1;
        end
      end
      if (rx_pos == `SNT_LAST_POS) begin
        next_out_valid = 1'b1;
        if (state != snt_pkg::activated_state) next_out = '1;
        else if (loop) next_out = tx_word;
        else next_out = rx_word;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_word        <= '1;
      echo           <= 1'b1;
      sync_cnt       <= 2'h0;
      sys_rx_word_o  <= '1;
      sys_rx_valid_o <= 1'b0;
    end else begin
      rx_word        <= next_rx_word;
      echo           <= next_echo;
      sync_cnt       <= next_sync;
      sys_rx_word_o  <= next_out;
      sys_rx_valid_o <= next_out_valid;
    end
  end

  // ---------------- transmit path ----------------
  snt_pkg::snt_info_t info;
  logic          last_pos;  // polarity of the last zero pulse
  logic          odd;       // zeros since last balance bit is odd
  logic          tst_pol;   // test pulse polarity
  logic          next_p;
  logic          next_n;
  logic          next_last_pos;
  logic          next_odd;
  logic          next_tst_pol;
  logic [WB-1:0] next_tx_word;
  logic          bit_v;
  logic          single;
  logic          cont;
  logic [6:0]    tx_map;

  always_comb begin
    unique case (state)
      snt_pkg::activated_state:           info = snt_pkg::info_four;
      snt_pkg::pending_activation_state,
      snt_pkg::wait_switch_state,
      snt_pkg::lost_line_state,
      snt_pkg::lost_up_state:             info = snt_pkg::info_two;
      default:                            info = snt_pkg::info_zero;
    endcase
    // test pulses override the line only
    cont   = (pin_v[4:2] == `SNT_TEST_CONT) | (cmd == `SNT_CONTINUOUS_PULSE_TEST);
    single = (pin_v[4:2] == `SNT_TEST_SINGLE) | (cmd == `SNT_SINGLE_PULSE_TEST);
    tx_map = snt_map(tx_pos);
    next_tx_word  = frame_end ? (buf_valid ? buf_word : '1) : tx_word;
    next_p        = tx_pos_o;
    next_n        = tx_neg_o;
    next_last_pos = last_pos;
    next_odd      = odd;
    next_tst_pol  = tst_pol;
    bit_v         = 1'b1;
    unique case (tx_pos)
      `SNT_POS_F, `SNT_POS_FA, `SNT_POS_M:                  bit_v = 1'b0;
      `SNT_POS_L1, `SNT_LAST_POS:                           bit_v = ~odd;
      `SNT_POS_A:                 bit_v = (info == snt_pkg::info_four);
      `SNT_POS_N:                                           bit_v = 1'b1;
      `SNT_POS_E0, `SNT_POS_E1, `SNT_POS_E2, `SNT_POS_E3:
        bit_v = echo & ~loop & (info == snt_pkg::info_four);
      default: begin
        if (tx_map[6]) bit_v = (info == snt_pkg::info_four) & tx_word[tx_map[5:0]];
      end
    endcase
    if (bit_tick) begin
      next_p = 1'b0;
      next_n = 1'b0;
      if (cont || (single && tx_pos == `SNT_POS_F)) begin
        next_p       = ~tst_pol;
        next_n       = tst_pol;
        next_tst_pol = ~tst_pol;
      end else if (!single && info != snt_pkg::info_zero && !bit_v) begin
        if (tx_pos == `SNT_POS_F || !last_pos) begin
          next_p        = 1'b1;
          next_last_pos = 1'b1;
        end else begin
          next_n        = 1'b1;
          next_last_pos = 1'b0;
        end
        next_odd = ~odd;
      end
      if (tx_pos == `SNT_POS_L1 || tx_pos == `SNT_LAST_POS) next_odd = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_pos_o <= 1'b0;
      tx_neg_o <= 1'b0;
      last_pos <= 1'b1;
      odd      <= 1'b0;
      tst_pol  <= 1'b0;
      tx_word  <= '1;
    end else begin
      tx_pos_o <= next_p;
      tx_neg_o <= next_n;
      last_pos <= next_last_pos;
      odd      <= next_odd;
      tst_pol  <= next_tst_pol;
      tx_word  <= next_tx_word;
    end
  end
endmodule

// >>> snt_monitor.sv
// port assertions of the s-bus nt transceiver
`timescale 1ns/10ps
`include "snt_consts.svh"
module snt_monitor (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      tx_pos_o,
  input wire logic                      tx_neg_o,
  input wire logic                      sys_tx_valid_i,
  input wire logic                      sys_tx_ready_o,
  input wire logic                      sys_rx_valid_o,
  input wire logic                      loop_closed_o,
  input wire logic [3:0]                sys_ind_o,
  input wire logic [`SNT_WORD_BITS-1:0] sys_rx_word_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // rest of a pulse of one bit period, four clocks on the bench
  sequence s_hold;
    tx_pos_o [*3];
  endsequence
  property p_excl; !(tx_pos_o && tx_neg_o); endproperty
  a_excl: assert property (p_excl) else $error("both pulse outputs high");
  property p_width; $rose(tx_pos_o) |=> s_hold; endproperty
  a_width: assert property (p_width) else $error("pulse shorter than a bit");
  property p_rst; $fell(rst_i) |-> sys_ind_o == 4'h0 && !tx_pos_o; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_ind; sys_ind_o inside {4'h0, 4'h4, 4'h8, 4'hC, 4'hF}; endproperty
  a_ind: assert property (p_ind) else $error("unknown indication code");
  property p_ones;
    sys_rx_valid_o && sys_ind_o != 4'hC && $past(sys_ind_o) != 4'hC |-> &sys_rx_word_o;
  endproperty
  a_ones: assert property (p_ones) else $error("data passed while not active");
  property p_gap; sys_rx_valid_o |=> !sys_rx_valid_o [*8]; endproperty
  a_gap: assert property (p_gap) else $error("receive strobes too close");
  property p_full; $fell(sys_tx_ready_o) |-> $past(sys_tx_valid_i); endproperty
  a_full: assert property (p_full) else $error("ready fell without a write");
  property p_loop; $rose(loop_closed_o) |-> ##[0:2] sys_ind_o inside {4'h8, 4'hC}; endproperty
  a_loop: assert property (p_loop) else $error("loop closed outside activation");
endmodule
bind snt_top snt_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .tx_pos_o(tx_pos_o),
  .tx_neg_o(tx_neg_o), .sys_tx_valid_i(sys_tx_valid_i), .sys_tx_ready_o(sys_tx_ready_o),
  .sys_rx_valid_o(sys_rx_valid_o), .loop_closed_o(loop_closed_o), .sys_ind_o(sys_ind_o),
  .sys_rx_word_o(sys_rx_word_o));

// >>> snt_te_model.sv
// terminal on the s/t line: silence, wake pattern or a steady zero stream
`timescale 1ns/10ps
module snt_te_model #(
  parameter int BIT_CYC = 4
) (
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  output logic            rx_pos_o = 1'b0,
  output logic            rx_neg_o = 1'b0
);
  int cyc;  // clocks within a bit
  int bitn; // bit within the wake pattern
  // own bit clock, unrelated to the transceiver's frame
  always @(posedge clk_i) begin
    cyc <= (cyc == BIT_CYC - 1) ? 0 : cyc + 1;
    if (cyc == BIT_CYC - 1) bitn <= (bitn + 1) % 8;
    // steady zeros in mode 2 keep any two-bit frame lag valid
    rx_pos_o <= mode_i == 2'h2 || (mode_i == 2'h1 && bitn == 0);
    rx_neg_o <= mode_i == 2'h1 && bitn == 1;
  end
endmodule

// >>> snt_tb.sv
// self-checking bench of the s-bus nt transceiver
`timescale 1ns/10ps
module tb;
  logic        clk_i, rst_i, sys_frame_i, sys_tx_valid_i, tx_pos_o, tx_neg_o, rdy, rxv, lp, rp, rn;
  logic [2:0]  tsel;
  logic [3:0]  sys_cmd_i, ind, keep;
  logic [1:0]  mode;
  logic [35:0] txw, rxw;
  int          miscompares, comparisons, fcnt, c;
  snt_top #(.BIT_CYC(10'h004), .T8_CYC(24'h000032), .T16_CYC(24'h000064),
    .T32_CYC(24'h0000C8)) uut (.clk_i(clk_i), .rst_i(rst_i), .rx_pos_i(rp), .rx_neg_i(rn),
    .test_select_pins_i(tsel), .tx_pos_o(tx_pos_o), .tx_neg_o(tx_neg_o),
    .sys_frame_i(sys_frame_i), .sys_cmd_i(sys_cmd_i), .sys_ind_o(ind), .sys_tx_word_i(txw),
    .sys_tx_valid_i(sys_tx_valid_i), .sys_tx_ready_o(rdy), .sys_rx_word_o(rxw),
    .sys_rx_valid_o(rxv), .loop_closed_o(lp));
  snt_te_model #(.BIT_CYC(4)) te (.clk_i(clk_i), .mode_i(mode), .rx_pos_o(rp), .rx_neg_o(rn));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // system frame strobe every eight clocks
  always @(posedge clk_i) begin
    #1;
    fcnt++;
    sys_frame_i = fcnt % 8 == 0;
  end
  task chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task cmd(input logic [3:0] k);
    sys_cmd_i = k;
    cyc(30);
  endtask
  task wait_ind(input logic [3:0] e);
    for (int n = 0; n < 3000 && ind !== e; n++) cyc(1);
    chk(36'(ind), 36'(e));
  endtask
  task pulses(input int n);
    c = 0;
    repeat (n) begin
      cyc(1);
      c += int'((tx_pos_o | tx_neg_o) !== 1'b0);
    end
  endtask
  task t_reset;
    chk(36'(ind), 36'h0);
    chk(rxw, '1);
    cyc(40);
    chk(36'(ind), 36'h0);
    cyc(20);
    chk(36'(ind), 36'hF);
  endtask
  task t_fill;
    sys_tx_valid_i = 1'b1;
    cyc(4);
    chk(36'(rdy), 36'h0);
    for (int n = 0; n < 500 && rdy !== 1'b1; n++) cyc(1);
    chk(36'(rdy), 36'h1);
    cyc(1);
    sys_tx_valid_i = 1'b0;
  endtask
  task t_act;
    mode = 2'h1;
    wait_ind(4'h8);
    cmd(4'h8);
    mode = 2'h2;
    cyc(800);
    cmd(4'hC);
    wait_ind(4'hC);
    cyc(1);
    for (int n = 0; n < 500 && rxv !== 1'b1; n++) cyc(1);
    chk(rxw, 36'h0);
    chk(36'(lp), 36'h0);
    cmd(4'h4);
    wait_ind(4'h4);
    cmd(4'hC);
    wait_ind(4'hC);
  endtask
  task t_deact;
    cmd(4'h0);
    mode = 2'h0;
    wait_ind(4'hF);
    pulses(200);
    chk(36'(c), 36'h0);
    cmd(4'hF);
    wait_ind(4'h0);
  endtask
  task t_loop;
    cmd(4'hA);
    chk(36'(lp), 36'h1);
    cmd(4'h1);
    chk(36'(lp), 36'h0);
    pulses(200);
    chk(36'(c), 36'h0);
  endtask
  task t_test;
    keep = ind;
    tsel = 3'h2;
    cyc(20);
    pulses(192);
    chk(36'(c), 36'hC0);
    tsel = 3'h3;
    cyc(400);
    pulses(192);
    chk(36'(c), 36'h4);
    chk(36'(ind), 36'(keep));
    tsel = 3'h0;
    cmd(4'h2);
    pulses(192);
    chk(36'(c), 36'h4);
  endtask
  task final_report;
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {rst_i, sys_cmd_i, txw, sys_tx_valid_i, tsel, mode} = {5'h1F, 36'h9A5C3E71B, 6'h0};
    cyc(3);
    rst_i = 0;
    t_reset;
    t_fill;
    t_act;
    t_deact;
    t_loop;
    t_test;
    final_report;
  end
  // cut a hang short
  initial begin
    #400000;
    miscompares++;
    final_report;
  end
endmodule
